// file: rtl/pafls_pkg.sv
// Constants for the port alternate-function and LED sink block
// Operation
// - Timer pins share one configuration; timer mode picks input or output.
// - LED sink mode only where the first select register picks it.
// - A pin's LED sink driver runs only with its enable bit set.
// - Four sink levels per LED pin, chosen by upper and lower levels.
// - Shared reset pin works both ways when configured as a port pin.
// - Every system reset returns the shared pin to its reset function.
// - Shared pin held low in reset function keeps the device in reset.
`default_nettype none
package pafls_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [11:0] OFF_LED_ENABLE      = 12'hF82;
   localparam logic [11:0] OFF_LED_LEVEL_UPPER = 12'hF83;
   localparam logic [11:0] OFF_LED_LEVEL_LOWER = 12'hF84;
   localparam logic [11:0] OFF_PC_ALT_ENABLE    = 12'hFE0;
   localparam logic [11:0] OFF_PC_ALT_SEL_FIRST = 12'hFE1;
   localparam logic [11:0] OFF_PC_ALT_SEL_SECOND = 12'hFE2;
   localparam logic [11:0] OFF_PC_DATA_OUT     = 12'hFE3;
   localparam logic [11:0] OFF_PC_DIR          = 12'hFE4;
   localparam logic [11:0] OFF_PC_DATA_IN      = 12'hFE5;
   localparam logic [11:0] OFF_PA_ALT_ENABLE   = 12'hFE8;
   localparam logic [11:0] OFF_PA_DATA_OUT     = 12'hFE9;
   localparam logic [11:0] OFF_PA_DIR          = 12'hFEA;
   localparam logic [11:0] OFF_PA_DATA_IN      = 12'hFEB;
   localparam logic [11:0] OFF_RESET_PIN_CTL   = 12'hFEC;

   // Reset values
   localparam logic [7:0] RST_LED_ENABLE   = 8'h00;
   localparam logic [7:0] RST_LED_LEVEL    = 8'h00;
   localparam logic [7:0] RST_ALT_FUNC     = 8'h00;
   localparam logic [7:0] RST_DATA_OUT     = 8'h00;
   localparam logic [7:0] RST_DIR          = 8'hFF;
   localparam logic       RST_RESET_PIN_GPIO = 1'b0;

   // Field positions on port A and in the reset pin control register
   localparam int unsigned PIN_TIMER_FIRST  = 0;
   localparam int unsigned PIN_SHARED_RESET = 2;
   localparam int unsigned PIN_TIMER_SECOND = 6;
   localparam int unsigned BIT_RESET_PIN_GPIO = 0;

   // Sink level codes, ascending current
   localparam logic [1:0] LVL_3MA  = 2'h0;
   localparam logic [1:0] LVL_7MA  = 2'h1;
   localparam logic [1:0] LVL_13MA = 2'h2;
   localparam logic [1:0] LVL_20MA = 2'h3;

endpackage
`default_nettype wire

// file: rtl/pafls_port.sv
// Port A/C pin control with timer sharing, LED sinks and shared reset pin
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pafls_port
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [11:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output var  logic [7:0]  bus_rdata,
   // Port A pins
   input  wire logic [7:0]  pa_in,
   output var  logic [7:0]  pa_out,
   output var  logic [7:0]  pa_oe,
   // Port C pins
   input  wire logic [7:0]  pc_in,
   output var  logic [7:0]  pc_out,
   output var  logic [7:0]  pc_oe,
   // LED sink pads
   output var  logic [7:0]  led_sink_on,
   output var  logic [15:0] led_level,
   // Timer side
   input  wire logic [1:0]  timer_capture_mode,
   input  wire logic        timer_out_first,
   input  wire logic        timer_out_second,
   output var  logic        timer_in_first,
   output var  logic        timer_in_second,
   // Reset controller side
   input  wire logic        sys_reset_event,
   output var  logic        reset_hold
);

   // Address hit test shared by every decode
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // Level code of one pin: upper bit over lower bit
   function automatic logic [1:0] lvl_code(input logic [7:0] up,
                                           input logic [7:0] lo,
                                           input int unsigned i);
      lvl_code = {up[i], lo[i]};
   endfunction

   // Pick the odd or even bits of a level vector
   function automatic logic [7:0] pick_bits(input logic [15:0] v,
                                            input logic        odd);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++)
         r[i] = v[2*i + (odd ? 1 : 0)];
      pick_bits = r;
   endfunction

   // Software registers
   logic [7:0] led_sink_enable;
   logic [7:0] led_sink_level_upper;
   logic [7:0] led_sink_level_lower;
   logic [7:0] pc_alt_func_enable;
   logic [7:0] alt_func_select_first;
   logic [7:0] alt_func_select_second;
   logic [7:0] pc_dout;
   logic [7:0] pc_dir;
   logic [7:0] pa_alt_func_enable;
   logic [7:0] pa_dout;
   logic [7:0] pa_dir;
   logic       reset_pin_gpio;

   // Pin synchronisers; stage one feeds stage two only
   logic [7:0] pa_s1;
   logic [7:0] pa_s2;
   logic [7:0] pc_s1;
   logic [7:0] pc_s2;

   // Write decode
   wire wr_led_en  = bus_wr && hit(bus_addr, pafls_pkg::OFF_LED_ENABLE);
   wire wr_lvl_up  = bus_wr && hit(bus_addr, pafls_pkg::OFF_LED_LEVEL_UPPER);
   wire wr_lvl_lo  = bus_wr && hit(bus_addr, pafls_pkg::OFF_LED_LEVEL_LOWER);
   wire wr_pc_alt  = bus_wr && hit(bus_addr, pafls_pkg::OFF_PC_ALT_ENABLE);
   wire wr_pc_s1   = bus_wr && hit(bus_addr, pafls_pkg::OFF_PC_ALT_SEL_FIRST);
   wire wr_pc_s2   = bus_wr && hit(bus_addr, pafls_pkg::OFF_PC_ALT_SEL_SECOND);
   wire wr_pc_do   = bus_wr && hit(bus_addr, pafls_pkg::OFF_PC_DATA_OUT);
   wire wr_pc_dir  = bus_wr && hit(bus_addr, pafls_pkg::OFF_PC_DIR);
   wire wr_pa_alt  = bus_wr && hit(bus_addr, pafls_pkg::OFF_PA_ALT_ENABLE);
   wire wr_pa_do   = bus_wr && hit(bus_addr, pafls_pkg::OFF_PA_DATA_OUT);
   wire wr_pa_dir  = bus_wr && hit(bus_addr, pafls_pkg::OFF_PA_DIR);
   wire wr_rst_ctl = bus_wr && hit(bus_addr, pafls_pkg::OFF_RESET_PIN_CTL);

   // Port C pin roles; the LED decode acts at once on the enable and first
   // select registers, so a half-written setup shows through, which is why software orders it
   wire [7:0] led_mode = pc_alt_func_enable & alt_func_select_first;
   wire [7:0] sink_now = led_mode & led_sink_enable;
   wire [7:0] next_pc_oe  = sink_now | (~pc_alt_func_enable & ~pc_dir);
   wire [7:0] next_pc_out = ~sink_now & pc_dout;

   // Shared pin is in reset function unless software chose port use and no system reset event is active
   wire rst_func = !reset_pin_gpio || sys_reset_event;

   // Port A pin roles
   logic [7:0]  next_pa_oe;
   logic [7:0]  next_pa_out;
   logic [15:0] next_led_level;
   always_comb
   begin
      next_pa_oe  = ~pa_alt_func_enable & ~pa_dir;
      next_pa_out = pa_dout;
      // Timer pins: one configuration, the timer mode picks the direction
      if (pa_alt_func_enable[pafls_pkg::PIN_TIMER_FIRST])
      begin
         next_pa_oe[pafls_pkg::PIN_TIMER_FIRST]  = !timer_capture_mode[0];
         next_pa_out[pafls_pkg::PIN_TIMER_FIRST] = timer_out_first;
      end
      if (pa_alt_func_enable[pafls_pkg::PIN_TIMER_SECOND])
      begin
         next_pa_oe[pafls_pkg::PIN_TIMER_SECOND]  = !timer_capture_mode[1];
         next_pa_out[pafls_pkg::PIN_TIMER_SECOND] = timer_out_second;
      end
      // Shared pin: input only in reset function, both ways otherwise
      if (rst_func)
      begin
         next_pa_oe[pafls_pkg::PIN_SHARED_RESET]  = 1'b0;
         next_pa_out[pafls_pkg::PIN_SHARED_RESET] = 1'b0;
      end
      else
      begin
         next_pa_oe[pafls_pkg::PIN_SHARED_RESET] =
            !pa_dir[pafls_pkg::PIN_SHARED_RESET];
         next_pa_out[pafls_pkg::PIN_SHARED_RESET] =
            pa_dout[pafls_pkg::PIN_SHARED_RESET];
      end
      // Per-pin sink level code
      for (int i = 0; i < 8; i++)
         next_led_level[2*i +: 2] =
            lvl_code(led_sink_level_upper, led_sink_level_lower, i);
   end

   // Held low in reset function, the pin keeps the chip in reset
   wire next_reset_hold =
      rst_func && !pa_s2[pafls_pkg::PIN_SHARED_RESET];

   // Read decode; unmapped addresses read zero
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      if (!bus_rd)
         next_rdata = 8'h00;
      else if (hit(bus_addr, pafls_pkg::OFF_LED_ENABLE))
         next_rdata = led_sink_enable;
      else if (hit(bus_addr, pafls_pkg::OFF_LED_LEVEL_UPPER))
         next_rdata = led_sink_level_upper;
      else if (hit(bus_addr, pafls_pkg::OFF_LED_LEVEL_LOWER))
         next_rdata = led_sink_level_lower;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_ALT_ENABLE))
         next_rdata = pc_alt_func_enable;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_ALT_SEL_FIRST))
         next_rdata = alt_func_select_first;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_ALT_SEL_SECOND))
         next_rdata = alt_func_select_second;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_DATA_OUT))
         next_rdata = pc_dout;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_DIR))
         next_rdata = pc_dir;
      else if (hit(bus_addr, pafls_pkg::OFF_PC_DATA_IN))
         next_rdata = pc_s2;
      else if (hit(bus_addr, pafls_pkg::OFF_PA_ALT_ENABLE))
         next_rdata = pa_alt_func_enable;
      else if (hit(bus_addr, pafls_pkg::OFF_PA_DATA_OUT))
         next_rdata = pa_dout;
      else if (hit(bus_addr, pafls_pkg::OFF_PA_DIR))
         next_rdata = pa_dir;
      else if (hit(bus_addr, pafls_pkg::OFF_PA_DATA_IN))
         next_rdata = pa_s2;
      else if (hit(bus_addr, pafls_pkg::OFF_RESET_PIN_CTL))
         next_rdata = {7'h00, reset_pin_gpio};
   end

   // LED and port C control registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         led_sink_enable        <= pafls_pkg::RST_LED_ENABLE;
         led_sink_level_upper   <= pafls_pkg::RST_LED_LEVEL;
         led_sink_level_lower   <= pafls_pkg::RST_LED_LEVEL;
         pc_alt_func_enable     <= pafls_pkg::RST_ALT_FUNC;
         alt_func_select_first  <= pafls_pkg::RST_ALT_FUNC;
         alt_func_select_second <= pafls_pkg::RST_ALT_FUNC;
         pc_dout                <= pafls_pkg::RST_DATA_OUT;
         pc_dir                 <= pafls_pkg::RST_DIR;
      end
      else
      begin
         if (wr_led_en) led_sink_enable <= bus_wdata;
         if (wr_lvl_up) led_sink_level_upper <= bus_wdata;
         if (wr_lvl_lo) led_sink_level_lower <= bus_wdata;
         if (wr_pc_alt) pc_alt_func_enable <= bus_wdata;
         if (wr_pc_s1) alt_func_select_first <= bus_wdata;
         if (wr_pc_s2) alt_func_select_second <= bus_wdata;
         if (wr_pc_do) pc_dout <= bus_wdata;
         if (wr_pc_dir) pc_dir <= bus_wdata;
      end
   end

   // Port A control; a system reset beats a same-cycle port-mode write
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pa_alt_func_enable <= pafls_pkg::RST_ALT_FUNC;
         pa_dout            <= pafls_pkg::RST_DATA_OUT;
         pa_dir             <= pafls_pkg::RST_DIR;
         reset_pin_gpio     <= pafls_pkg::RST_RESET_PIN_GPIO;
      end
      else
      begin
         if (wr_pa_alt) pa_alt_func_enable <= bus_wdata;
         if (wr_pa_do) pa_dout <= bus_wdata;
         if (wr_pa_dir) pa_dir <= bus_wdata;
         if (sys_reset_event)
            reset_pin_gpio <= 1'b0;
         else if (wr_rst_ctl)
            reset_pin_gpio <= bus_wdata[pafls_pkg::BIT_RESET_PIN_GPIO];
      end
   end

   // Synchronisers; they clear to low so a reset pin reads held at first
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pa_s1 <= 8'h00;
         pa_s2 <= 8'h00;
         pc_s1 <= 8'h00;
         pc_s2 <= 8'h00;
      end
      else
      begin
         pa_s1 <= pa_in;
         pa_s2 <= pa_s1;
         pc_s1 <= pc_in;
         pc_s2 <= pc_s1;
      end
   end

   // Registered outputs; reset hold starts asserted until the pin is seen
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bus_rdata       <= 8'h00;
         pa_out          <= 8'h00;
         pa_oe           <= 8'h00;
         pc_out          <= 8'h00;
         pc_oe           <= 8'h00;
         led_sink_on     <= 8'h00;
         led_level       <= 16'h0000;
         timer_in_first  <= 1'b0;
         timer_in_second <= 1'b0;
         reset_hold      <= 1'b1;
      end
      else
      begin
         bus_rdata       <= next_rdata;
         pa_out          <= next_pa_out;
         pa_oe           <= next_pa_oe;
         pc_out          <= next_pc_out;
         pc_oe           <= next_pc_oe;
         led_sink_on     <= sink_now;
         led_level       <= next_led_level;
         timer_in_first  <= pa_s2[pafls_pkg::PIN_TIMER_FIRST];
         timer_in_second <= pa_s2[pafls_pkg::PIN_TIMER_SECOND];
         reset_hold      <= next_reset_hold;
      end
   end

   // Checks
   timer_in_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(pa_alt_func_enable[0]) && $past(timer_capture_mode[0])
      |-> !pa_oe[0])
      else $error("timer pin drives while timer takes input");

   timer_out_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(pa_alt_func_enable[6]) && !$past(timer_capture_mode[1])
      |-> pa_oe[6] && (pa_out[6] == $past(timer_out_second)))
      else $error("timer pin does not carry timer output");

   led_mode_a: assert property (@(posedge clk) disable iff (!rstn)
      (led_sink_on & ~$past(led_mode)) == 8'h00)
      else $error("LED sink on outside LED mode");

   led_enable_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_led_en && (bus_wdata == 8'h00) |-> ##2 (led_sink_on == 8'h00))
      else $error("LED sink stays on after enable cleared");

   led_level_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_lvl_up |-> ##2 (pick_bits(led_level, 1'b1) == $past(bus_wdata, 2)))
      else $error("upper level write not seen on level code");

   level_code_a: assert property (@(posedge clk) disable iff (!rstn)
      pick_bits(led_level, 1'b0) == $past(led_sink_level_lower))
      else $error("lower level bits misplaced in level code");

   gpio_bidir_a: assert property (@(posedge clk) disable iff (!rstn)
      $past(reset_pin_gpio) && !$past(sys_reset_event) && !$past(pa_dir[2])
      |-> pa_oe[2] && (pa_out[2] == $past(pa_dout[2])))
      else $error("shared pin fails to drive in port mode");

   pin_revert_a: assert property (@(posedge clk) disable iff (!rstn)
      sys_reset_event |=> !reset_pin_gpio && !pa_oe[2] ##1 !pa_oe[2])
      else $error("shared pin kept port mode over system reset");

   reset_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !reset_pin_gpio && !sys_reset_event
      |=> (reset_hold == !$past(pa_s2[2])))
      else $error("reset hold does not follow shared pin");

endmodule // pafls_port
`default_nettype wire

// file: tb/pafls_pins.sv
// Model of the pull-ups, LED loads and outside drivers on the port pins
`timescale 1ns/100ps
`default_nettype none
module pafls_pins
(
   // Pad side of the block
   input  wire logic [7:0] pa_out,
   input  wire logic [7:0] pa_oe,
   input  wire logic [7:0] pc_out,
   input  wire logic [7:0] pc_oe,
   // Outside source pulling a pin low, set by the bench
   input  wire logic [7:0] ext_low,
   // Wire levels back to the block
   output wire logic [7:0] pa_in,
   output wire logic [7:0] pc_in
);
   // Pull-ups on port A; a hard outside low beats a weak drive
   assign pa_in = ~ext_low & ((pa_oe & pa_out) | ~pa_oe);
   // LED anodes sit at the supply, so an undriven pin reads high
   assign pc_in = (pc_oe & pc_out) | ~pc_oe;
endmodule // pafls_pins
`default_nettype wire

// file: tb/port_alt_function_led_sink_tb.sv
// Register and pin tests for the port alternate-function block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module port_alt_function_led_sink_tb;
   logic        clk, rstn, bus_wr, bus_rd, sys_reset_event;
   logic        timer_out_first, timer_out_second;
   logic        timer_in_first, timer_in_second, reset_hold;
   logic [1:0]  timer_capture_mode;
   logic [11:0] bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, pa_in, pa_out, pa_oe, d;
   logic [7:0]  pc_in, pc_out, pc_oe, led_sink_on, ext_low;
   logic [15:0] led_level, lvl_exp;
   int          fails, check_count;

   pafls_port pafls_port_i (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
      .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
      .led_sink_on(led_sink_on), .led_level(led_level),
      .timer_capture_mode(timer_capture_mode),
      .timer_out_first(timer_out_first), .timer_out_second(timer_out_second),
      .timer_in_first(timer_in_first), .timer_in_second(timer_in_second),
      .sys_reset_event(sys_reset_event), .reset_hold(reset_hold));
   pafls_pins pafls_pins_i (.pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out),
      .pc_oe(pc_oe), .ext_low(ext_low), .pa_in(pa_in), .pc_in(pc_in));

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // One write cycle; strobe drops after the edge that takes it
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= v;
      @(posedge clk);
      bus_wr    <= 1'b0;
   endtask

   // One read cycle; data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      @(posedge clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1 v = bus_rdata;
   endtask

   // Let n edges pass, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under 1000 cycles
   initial
   begin
      #200000;
      fails++;
      results();
   end

   initial
   begin
      rstn = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 12'h000;
      bus_wdata = 8'h00;
      sys_reset_event = 1'b0;
      timer_capture_mode = 2'h0;
      timer_out_first = 1'b0;
      timer_out_second = 1'b0;
      ext_low = 8'h00;
      fails = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // Reset values, an unmapped place, then write and read back
      cyc(6);
      `CHK("reset_hold idle", 1'b0, reset_hold)
      for (int a = 'hF82; a <= 'hF85; a++)
      begin
         rd(a[11:0], d);
         `CHK("reset value", 8'h00, d)
      end
      for (int a = 'hF82; a <= 'hF84; a++)
      begin
         wr(a[11:0], 8'hA5 ^ a[7:0]);
         rd(a[11:0], d);
         `CHK("readback", 8'hA5 ^ a[7:0], d)
      end
      $display("test registers done");
      // LED mode only on selected pins, driver only where enabled
      wr(12'hFE1, 8'h0F);
      wr(12'hFE2, 8'h00);
      wr(12'hFE0, 8'hFF);
      wr(12'hF82, 8'hF5);
      cyc(2);
      `CHK("led_sink_on", 8'h05, led_sink_on)
      `CHK("pc_oe", 8'h05, pc_oe)
      `CHK("pc_out sink", 8'h00, pc_out & 8'h05)
      cyc(2);
      rd(12'hFE5, d);
      `CHK("pc pins", 8'hFA, d)
      // Clearing the enable must drop every sink driver
      wr(12'hF82, 8'h00);
      cyc(2);
      `CHK("led off", 8'h00, led_sink_on)
      $display("test led enable done");
      // All four level codes on pins 0 to 3
      wr(12'hF83, 8'h0C);
      wr(12'hF84, 8'h0A);
      for (int i = 0; i < 8; i++)
         lvl_exp[2*i +: 2] = {1'(8'h0C >> i), 1'(8'h0A >> i)};
      cyc(2);
      `CHK("led_level", lvl_exp, led_level)
      `CHK("level codes", 8'hE4, led_level[7:0])
      $display("test led level done");
      // Timer pins: output mode, then input mode on the same setup
      wr(12'hFE8, 8'h41);
      timer_out_first <= 1'b1;
      cyc(2);
      `CHK("timer oe", 8'h41, pa_oe & 8'h41)
      `CHK("timer out", 2'b01, {pa_out[6], pa_out[0]})
      @(posedge clk);
      timer_capture_mode <= 2'h3;
      ext_low <= 8'h01;
      cyc(4);
      `CHK("timer oe in", 8'h00, pa_oe & 8'h41)
      `CHK("timer in", 2'b10, {timer_in_second, timer_in_first})
      ext_low <= 8'h00;
      $display("test timer pins done");
      // Shared pin as a port pin both ways, then a system reset
      wr(12'hFEC, 8'h01);
      wr(12'hFEA, 8'hFB);
      wr(12'hFE9, 8'h04);
      cyc(2);
      `CHK("shared drive", 2'b11, {pa_oe[2], pa_out[2]})
      wr(12'hFEA, 8'hFF);
      ext_low <= 8'h04;
      cyc(4);
      rd(12'hFEB, d);
      `CHK("shared input", 1'b0, d[2])
      `CHK("no hold in port mode", 1'b0, reset_hold)
      // Drive the pin again so the revert has something to undo
      wr(12'hFEA, 8'hFB);
      cyc(2);
      `CHK("port drive again", 1'b1, pa_oe[2])
      @(posedge clk);
      sys_reset_event <= 1'b1;
      @(posedge clk);
      sys_reset_event <= 1'b0;
      cyc(4);
      `CHK("shared oe", 1'b0, pa_oe[2])
      `CHK("hold low pin", 1'b1, reset_hold)
      rd(12'hFEC, d);
      `CHK("reverted", 1'b0, d[0])
      cyc(20);
      `CHK("still held", 1'b1, reset_hold)
      ext_low <= 8'h00;
      cyc(5);
      `CHK("released", 1'b0, reset_hold)
      $display("test shared pin done");
      results();
   end
endmodule // port_alt_function_led_sink_tb
`default_nettype wire
